// ==== gst_pkg.sv ====
// Constants shared by the gated sixteen-bit timer files.
// Assumes a single 50 MHz core clock and an AXI4-Lite register port.
package gst_pkg;
	// Register byte addresses.
	localparam logic [4:0] ADDR_LOW  = 5'h00;
	localparam logic [4:0] ADDR_HIGH = 5'h04;
	localparam logic [4:0] ADDR_CTRL = 5'h08;
	localparam logic [4:0] ADDR_GATE = 5'h0c;
	localparam logic [4:0] ADDR_STAT = 5'h10;
	// Control register fields.
	localparam int CTRL_ON     = 0;
	localparam int CTRL_SRC    = 1;
	localparam int CTRL_NOSYNC = 2;
	localparam int CTRL_OSC    = 3;
	localparam int CTRL_PS     = 4;
	localparam int CTRL_GE     = 6;
	localparam int CTRL_GINV   = 7;
	// Gate register fields.
	localparam int GATE_SEL    = 1;
	localparam int GATE_CSYNC  = 0;
	// Status register fields.
	localparam int STAT_OVF    = 0;
	localparam int STAT_OSC    = 1;
	localparam int STAT_FORCE  = 2;
	// Reset values.
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  GATE_RST  = 8'h02;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// Prescale select codes.
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV2 = 2'h1;
	localparam logic [1:0] PS_DIV4 = 2'h2;
	localparam logic [1:0] PS_DIV8 = 2'h3;
	// Core clock cycles per instruction cycle.
	localparam int INSTR_DIV = 4;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== gst_cnt_if.sv ====
// Link between the timer control logic and its counter core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface gst_cnt_if;
	logic        tick;
	logic        clear_pre;
	logic        wr_lo;
	logic        wr_hi;
	logic [7:0]  wdata;
	logic [1:0]  ps_sel;
	logic [15:0] count;
	logic        ovf;
	modport ctl  (output tick, clear_pre, wr_lo, wr_hi, wdata, ps_sel, input count, ovf);
	modport core (input tick, clear_pre, wr_lo, wr_hi, wdata, ps_sel, output count, ovf);
endinterface

// ==== gst_core.sv ====
// Prescaler and sixteen-bit counter of the gated timer.
// Assumes one tick input per selected source clock, already gated.
`timescale 1ns/1ps
module gst_core #(
	parameter int PRE_W = 3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Control link.
	gst_cnt_if.core  bus
);
	logic [PRE_W-1:0] pre;
	logic             pre_done;
	logic             byte_wr;

	// The prescaler must reach a division of eight.
	if (PRE_W < 3) begin : g_chk
		$error("PRE_W must be at least 3");
	end

	// Returns the prescale terminal mask for a select code.
	function automatic logic [PRE_W-1:0] ps_mask(input logic [1:0] sel);
		unique case (sel)
			gst_pkg::PS_DIV1: return PRE_W'(3'h0);
			gst_pkg::PS_DIV2: return PRE_W'(3'h1);
			gst_pkg::PS_DIV4: return PRE_W'(3'h3);
			gst_pkg::PS_DIV8: return PRE_W'(3'h7);
		endcase
	endfunction

	// The prescale output fires when the masked count is full.
	assign pre_done = (pre & ps_mask(bus.ps_sel)) == ps_mask(bus.ps_sel);
	assign byte_wr  = bus.wr_lo | bus.wr_hi;

	// Prescale counter, hidden from software and cleared by a byte write.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre <= '0;
		end else if (bus.clear_pre) begin
			pre <= '0;
		end else if (bus.tick) begin
			pre <= pre_done ? '0 : pre + PRE_W'(1);
		end
	end

	// Counter: a byte write wins over an increment in the same cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus.count <= gst_pkg::COUNT_RST;
			bus.ovf   <= 1'b0;
		end else begin
			bus.ovf <= bus.tick && pre_done && !byte_wr && bus.count == 16'hffff;
			if (bus.wr_lo) begin
				bus.count[7:0] <= bus.wdata;
			end else if (bus.wr_hi) begin
				bus.count[15:8] <= bus.wdata;
			end else if (bus.tick && pre_done) begin
				bus.count <= bus.count + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_wrap_to_zero: assert property (bus.tick && pre_done && !byte_wr && bus.count == 16'hffff |=> bus.count == 16'h0000 && bus.ovf)
		else $error("Counter did not wrap with an overflow pulse");
	a_div_eight: assert property (bus.ps_sel == gst_pkg::PS_DIV8 && bus.tick && pre != PRE_W'(3'h7) && !byte_wr && !bus.clear_pre |=> $stable(bus.count))
		else $error("Divide by eight advanced early");
	a_pre_clear: assert property (bus.clear_pre |=> pre == '0)
		else $error("Prescaler not cleared by a byte write");
endmodule

// ==== gst_top.sv ====
// Gated sixteen-bit timer with AXI4-Lite registers.
// Assumes one 50 MHz core clock; count and gate pins are asynchronous.
`timescale 1ns/1ps
module gst_top (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address and data.
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Count and gate sources.
	input  wire logic        external_count_input,
	input  wire logic        crystal_input_pin,
	input  wire logic        gate_pin,
	input  wire logic        second_comparator_output,
	// Core status.
	input  wire logic        core_sleep,
	input  wire logic        internal_oscillator,
	input  wire logic        low_power_crystal_mode,
	// Outputs to the system.
	output logic             crystal_osc_run,
	output logic             porta_force,
	output logic             overflow_flag,
	output logic             wake_request
);
	gst_cnt_if cnt_if ();

	// Register state.
	logic [7:0]  ctrl;
	logic [7:0]  gate_cfg;
	// Write channel holding state.
	logic        aw_held;
	logic        w_held;
	logic [4:0]  waddr;
	logic [7:0]  wbyte;
	logic        wlane;
	logic        wr_fire;
	logic        wr_hit;
	// Decoded control fields.
	logic        on_bit;
	logic        src;
	logic        nosync;
	logic        gate_en;
	logic        ginv;
	logic        byte_wr;
	// Instruction clock divider.
	logic [1:0]  div;
	logic        instr_en;
	// External input sampler and edge state.
	logic        ext_src;
	logic        ext_s1;
	logic        ext_s2;
	logic        ext_s3;
	logic        ext_lvl;
	logic        ext_prev;
	logic        ext_rise;
	logic        ext_fall;
	logic        armed;
	logic        ext_event;
	logic        pend;
	// Gate sampler and decision.
	logic        gate_s1;
	logic        gate_s2;
	logic        gate_s3;
	logic        gate_lvl;
	logic        gate_level;
	logic        gate_ok;
	// Run decision.
	logic        osc_allowed;
	logic        run;

	// Returns true when an address names a mapped register.
	function automatic logic addr_mapped(input logic [4:0] a);
		return a == gst_pkg::ADDR_LOW || a == gst_pkg::ADDR_HIGH ||
			a == gst_pkg::ADDR_CTRL || a == gst_pkg::ADDR_GATE ||
			a == gst_pkg::ADDR_STAT;
	endfunction

	// Control fields.
	assign on_bit  = ctrl[gst_pkg::CTRL_ON];
	assign src     = ctrl[gst_pkg::CTRL_SRC];
	assign nosync  = ctrl[gst_pkg::CTRL_NOSYNC];
	assign gate_en = ctrl[gst_pkg::CTRL_GE];
	assign ginv    = ctrl[gst_pkg::CTRL_GINV];

	// Write channel readiness; both halves are taken in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit        = wr_fire && wlane;
	assign s_axi_arready = !s_axi_rvalid;

	// Hold the write address and data until both have arrived.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			waddr   <= 5'h00;
			wbyte   <= 8'h00;
			wlane   <= 1'b0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				waddr   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wbyte  <= s_axi_wdata[7:0];
				wlane  <= s_axi_wstrb[0];
			end
		end
	end

	// Write response, one cycle after both halves are held.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= gst_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_mapped(waddr) ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control and gate registers; only byte lane zero carries bits.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl     <= gst_pkg::CTRL_RST;
			gate_cfg <= gst_pkg::GATE_RST;
		end else if (wr_hit && waddr == gst_pkg::ADDR_CTRL) begin
			ctrl <= wbyte;
		end else if (wr_hit && waddr == gst_pkg::ADDR_GATE) begin
			gate_cfg <= {6'h00, wbyte[1:0]};
		end
	end

	// Byte writes go to the counter core and clear its prescaler.
	assign cnt_if.wr_lo     = wr_hit && waddr == gst_pkg::ADDR_LOW;
	assign cnt_if.wr_hi     = wr_hit && waddr == gst_pkg::ADDR_HIGH;
	assign cnt_if.wdata     = wbyte;
	assign cnt_if.clear_pre = byte_wr;
	assign cnt_if.ps_sel    = ctrl[gst_pkg::CTRL_PS +: 2];
	assign byte_wr          = cnt_if.wr_lo | cnt_if.wr_hi;

	// Read answer one cycle after the address; the counter shares this clock, so reads are whole.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= gst_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_mapped(s_axi_araddr) ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				gst_pkg::ADDR_LOW:  s_axi_rdata <= {24'h000000, cnt_if.count[7:0]};
				gst_pkg::ADDR_HIGH: s_axi_rdata <= {24'h000000, cnt_if.count[15:8]};
				gst_pkg::ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl};
				gst_pkg::ADDR_GATE: s_axi_rdata <= {24'h000000, gate_cfg};
				gst_pkg::ADDR_STAT: s_axi_rdata <= {29'h0, porta_force, crystal_osc_run, overflow_flag};
				default:            s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Overflow flag: a new overflow wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overflow_flag <= 1'b0;
			wake_request  <= 1'b0;
		end else begin
			wake_request <= cnt_if.ovf && core_sleep;
			if (cnt_if.ovf) begin
				overflow_flag <= 1'b1;
			end else if (wr_hit && waddr == gst_pkg::ADDR_STAT && wbyte[gst_pkg::STAT_OVF]) begin
				overflow_flag <= 1'b0;
			end
		end
	end

	// Oscillator control; the port A override follows the same flop.
	assign osc_allowed = internal_oscillator | low_power_crystal_mode;
	assign porta_force = crystal_osc_run;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			crystal_osc_run <= 1'b0;
		end else begin
			crystal_osc_run <= ctrl[gst_pkg::CTRL_OSC] && osc_allowed;
		end
	end

	// Instruction clock enable: one core clock in four.
	assign instr_en = div == 2'(gst_pkg::INSTR_DIV - 1);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end

	// External source: the crystal when it runs, else the count pin.
	assign ext_src = crystal_osc_run ? crystal_input_pin : external_count_input;
	// Three-flop sampler; the level moves once stages two and three agree.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_s1   <= 1'b0;
			ext_s2   <= 1'b0;
			ext_s3   <= 1'b0;
			ext_lvl  <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_s1   <= ext_src;
			ext_s2   <= ext_s1;
			ext_s3   <= ext_s2;
			ext_prev <= ext_lvl;
			if (ext_s2 == ext_s3) begin
				ext_lvl <= ext_s3;
			end
		end
	end

	assign ext_rise  = ext_lvl && !ext_prev;
	assign ext_fall  = !ext_lvl && ext_prev;
	assign ext_event = ext_rise && armed && src;
	// Arming: lost when stopped or written, regained on a falling edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b0;
		end else if (!on_bit || byte_wr) begin
			armed <= 1'b0;
		end else if (ext_fall) begin
			armed <= 1'b1;
		end
	end

	// Sync mode holds an edge until the next instruction cycle; leaving it drops that edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend <= 1'b0;
		end else if (!on_bit || byte_wr || nosync) begin
			pend <= 1'b0;
		end else if (ext_event) begin
			pend <= 1'b1;
		end else if (instr_en) begin
			pend <= 1'b0;
		end
	end

	// Gate pin sampler, same scheme as the count input.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gate_s1  <= 1'b0;
			gate_s2  <= 1'b0;
			gate_s3  <= 1'b0;
			gate_lvl <= 1'b0;
		end else begin
			gate_s1 <= gate_pin;
			gate_s2 <= gate_s1;
			gate_s3 <= gate_s2;
			if (gate_s2 == gate_s3) begin
				gate_lvl <= gate_s3;
			end
		end
	end

	// Gate choice and polarity, then the overall run decision.
	assign gate_level = gate_cfg[gst_pkg::GATE_SEL] ? second_comparator_output : gate_lvl;
	assign gate_ok    = !gate_en || (ginv ? gate_level : !gate_level);
	assign run        = on_bit && gate_ok && (!core_sleep || (src && nosync));

	// Tick to the prescaler from the selected source.
	always_comb begin
		if (!run) begin
			cnt_if.tick = 1'b0;
		end else if (!src) begin
			cnt_if.tick = instr_en;
		end else if (nosync) begin
			cnt_if.tick = ext_event;
		end else begin
			cnt_if.tick = instr_en && pend;
		end
	end

	gst_core #(
		.PRE_W (3)
	) u_core (
		.clk  (clk),
		.rstn (rstn),
		.bus  (cnt_if.core)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_sync_edge;
		ext_event && run && !nosync && !byte_wr;
	endsequence
	sequence s_sync_tick;
		##[1:4] (cnt_if.tick || byte_wr || !run || nosync);
	endsequence
	property p_sync_count;
		s_sync_edge |-> s_sync_tick;
	endproperty
	a_sync_edge_count: assert property (p_sync_count)
		else $error("Synchronised edge not counted in time");
	a_async_edge_now: assert property (ext_event && run && nosync |-> cnt_if.tick)
		else $error("Unsynchronised edge not counted at once");
	a_internal_rate: assert property (cnt_if.tick && !src |-> instr_en && on_bit)
		else $error("Internal tick off the instruction clock");
	a_fall_first: assert property (byte_wr ##1 !ext_fall [*1] |-> !ext_event)
		else $error("Rising edge counted without a prior fall");
	a_stopped_hold: assert property (!on_bit && !byte_wr |=> $stable(cnt_if.count))
		else $error("Counter moved while stopped");
	a_gate_blocks: assert property (on_bit && gate_en && (ginv ? !gate_level : gate_level) |-> !cnt_if.tick)
		else $error("Counted while gate inactive");
	a_byte_load: assert property (cnt_if.wr_lo |=> cnt_if.count[7:0] == $past(wbyte))
		else $error("Low byte write not loaded");
	a_flag_sets: assert property (cnt_if.ovf |=> overflow_flag)
		else $error("Overflow did not set the flag");
	a_osc_gated: assert property (!osc_allowed |=> !crystal_osc_run && !porta_force)
		else $error("Oscillator ran without an allowed primary clock");
	a_sleep_hold: assert property (core_sleep && !(src && nosync) && !byte_wr |=> $stable(cnt_if.count))
		else $error("Counter moved in sleep outside asynchronous mode");
endmodule

// ==== gst_src_model.sv ====
// Model of the timer's outside world: count clock, crystal, gate pin and comparator.
// Assumes the bench calls its tasks and that it shares the core clock.
`timescale 1ns/1ps
module gst_src_model (
	// Core clock.
	input  wire logic clk,
	// Sources seen by the timer.
	output logic      ext_clk,
	output logic      xtal_clk,
	output logic      gate_lvl,
	output logic      cmp_lvl
);
	// Every source idles low, so a clock stands still outside its frames.
	initial begin
		ext_clk  = 1'h0;
		xtal_clk = 1'h0;
		gate_lvl = 1'h0;
		cmp_lvl  = 1'h0;
	end

	// Sends n periods, rising first, each half lasting half core cycles.
	task automatic pulses(input int n, input int half, input logic on_xtal);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge clk);
			ext_clk  <= on_xtal ? ext_clk : 1'h1;
			xtal_clk <= on_xtal ? 1'h1 : xtal_clk;
			repeat (half) @(posedge clk);
			ext_clk  <= 1'h0;
			xtal_clk <= 1'h0;
		end
	endtask

	// Sets the gate pin and comparator levels at the next edge.
	task automatic set_gate(input logic g, input logic c);
		@(posedge clk);
		gate_lvl <= g;
		cmp_lvl  <= c;
	endtask
endmodule

// ==== tb_gated_sixteen_bit_timer.sv ====
// Self-checking bench for the gated sixteen-bit timer.
// Assumes gst_pkg, gst_top and gst_src_model are compiled before it.
`timescale 1ns/1ps
module tb_gated_sixteen_bit_timer;
	logic        clk, rstn, sleep, prim_int, prim_xtal;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        ext, xtal, gpin, cmp, osc_run, pforce, ovf, wake;
	int          err_total, checked, cyc, wakes;

	gst_top DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_count_input(ext), .crystal_input_pin(xtal), .gate_pin(gpin),
		.second_comparator_output(cmp), .core_sleep(sleep), .internal_oscillator(prim_int),
		.low_power_crystal_mode(prim_xtal), .crystal_osc_run(osc_run),
		.porta_force(pforce), .overflow_flag(ovf), .wake_request(wake));

	gst_src_model src (.clk(clk), .ext_clk(ext), .xtal_clk(xtal), .gate_lvl(gpin),
		.cmp_lvl(cmp));

	// Core clock at 50 MHz.
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Cycle count and count of wake pulses.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake) wakes <= wakes + 1;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One AXI4-Lite write; each channel is released at the edge that takes it.
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		n = 0;
		tb = 1'h0;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'h1;
		wdata   <= {24'h000000, d};
		wstrb   <= 4'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r  = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) bready <= 1'h0;
			n++;
			if (n > 50) begin
				err_total++;
				end_sim();
			end
		end
		chk(32'(r), 32'(er));
	endtask

	// One AXI4-Lite read, held until the data are taken.
	task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		logic ta, tr;
		logic [1:0] r;
		n = 0;
		tr = 1'h0;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'h0;
			if (tr) rready <= 1'h0;
			n++;
			if (n > 50) begin
				err_total++;
				end_sim();
			end
		end
		chk(32'(r), 32'(er));
	endtask

	// Counter access as two bytes, low first.
	task automatic rdc(output logic [15:0] c);
		logic [31:0] d;
		rd(gst_pkg::ADDR_LOW, gst_pkg::RESP_OKAY, d);
		c[7:0] = d[7:0];
		rd(gst_pkg::ADDR_HIGH, gst_pkg::RESP_OKAY, d);
		c[15:8] = d[7:0];
	endtask
	task automatic wc(input logic [15:0] v);
		wr(gst_pkg::ADDR_LOW, v[7:0], gst_pkg::RESP_OKAY);
		wr(gst_pkg::ADDR_HIGH, v[15:8], gst_pkg::RESP_OKAY);
	endtask

	// Reset values, unmapped place and byte replacement.
	task automatic t_reset();
		logic [31:0] d;
		logic [15:0] c;
		rd(gst_pkg::ADDR_CTRL, gst_pkg::RESP_OKAY, d);
		chk(d, 32'(gst_pkg::CTRL_RST));
		rd(gst_pkg::ADDR_GATE, gst_pkg::RESP_OKAY, d);
		chk(d, 32'(gst_pkg::GATE_RST));
		rdc(c);
		chk(32'(c), 32'(gst_pkg::COUNT_RST));
		rd(5'h14, gst_pkg::RESP_SLVERR, d);
		chk(d, 32'h0);
		wr(5'h14, 8'hff, gst_pkg::RESP_SLVERR);
		wc(16'ha55a);
		rdc(c);
		chk(32'(c), 32'ha55a);
		$display("test reset done");
	endtask

	// Internal source at each prescale code, then with the timer off.
	task automatic t_int();
		int t0, t1, e;
		logic [15:0] c;
		for (int ps = 0; ps < 4; ps++) begin
			wc(16'h0000);
			t0 = cyc;
			wr(gst_pkg::ADDR_CTRL, 8'h01 | 8'(ps << 4), gst_pkg::RESP_OKAY);
			repeat (40 << ps) @(posedge clk);
			t1 = cyc;
			wr(gst_pkg::ADDR_CTRL, 8'h00, gst_pkg::RESP_OKAY);
			rdc(c);
			e = (t1 - t0) / (gst_pkg::INSTR_DIV << ps);
			chk(32'(int'(c) >= e - 1 && int'(c) <= e + 1), 32'h1);
		end
		wc(16'h0000);
		repeat (40) @(posedge clk);
		rdc(c);
		chk(32'(c), 32'h0);
		$display("test internal done");
	endtask

	// External frame; the line idles low, so the first rise is not counted.
	task automatic xc(input logic [7:0] ctl, input logic sl, input logic [15:0] st,
		input int n, input logic xt, input logic [15:0] ev, input int ew);
		int w0;
		logic [15:0] c;
		wc(st);
		@(posedge clk);
		sleep <= sl;
		w0 = wakes;
		wr(gst_pkg::ADDR_CTRL, ctl, gst_pkg::RESP_OKAY);
		src.pulses(n, 6, xt);
		repeat (12) @(posedge clk);
		sleep <= 1'h0;
		rdc(c);
		chk(32'(c), 32'(ev));
		chk(32'(wakes - w0), 32'(ew));
	endtask

	// Sync, async, prescaled, sleeping and overflowing external counts.
	task automatic t_ext();
		logic [31:0] d;
		xc(8'h03, 1'h0, 16'h0000, 4, 1'h0, 16'h0003, 0);
		xc(8'h07, 1'h0, 16'h00fe, 4, 1'h0, 16'h0101, 0);
		xc(8'h13, 1'h0, 16'h0000, 5, 1'h0, 16'h0002, 0);
		xc(8'h03, 1'h1, 16'h0000, 3, 1'h0, 16'h0000, 0);
		xc(8'h07, 1'h1, 16'hffff, 2, 1'h0, 16'h0000, 1);
		chk(32'(ovf), 32'h1);
		rd(gst_pkg::ADDR_STAT, gst_pkg::RESP_OKAY, d);
		chk(32'(d[gst_pkg::STAT_OVF]), 32'h1);
		wr(gst_pkg::ADDR_STAT, 8'h01, gst_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(32'(ovf), 32'h0);
		$display("test external done");
	endtask

	// Crystal oscillator: start-up wait, counting, permission and port forcing.
	task automatic t_osc();
		logic [31:0] d;
		wr(gst_pkg::ADDR_CTRL, 8'h08, gst_pkg::RESP_OKAY);
		repeat (20) @(posedge clk);
		chk(32'(osc_run), 32'h1);
		chk(32'(pforce), 32'h1);
		rd(gst_pkg::ADDR_STAT, gst_pkg::RESP_OKAY, d);
		chk(32'(d[gst_pkg::STAT_FORCE:gst_pkg::STAT_OSC]), 32'h3);
		xc(8'h0b, 1'h0, 16'h0000, 3, 1'h1, 16'h0002, 0);
		prim_int <= 1'h0;
		repeat (3) @(posedge clk);
		chk(32'(osc_run), 32'h0);
		prim_xtal <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(osc_run), 32'h1);
		wr(gst_pkg::ADDR_CTRL, 8'h00, gst_pkg::RESP_OKAY);
		repeat (3) @(posedge clk);
		chk(32'(pforce), 32'h0);
		$display("test oscillator done");
	endtask

	// Every gate source, polarity and level; the unselected source is opposite.
	task automatic t_gate();
		logic sel, inv, lvl;
		logic [15:0] c;
		for (int k = 0; k < 8; k++) begin
			sel = k[2];
			inv = k[1];
			lvl = k[0];
			wr(gst_pkg::ADDR_GATE, {6'h00, sel, 1'h0}, gst_pkg::RESP_OKAY);
			src.set_gate(sel ? !lvl : lvl, sel ? lvl : !lvl);
			wc(16'h0000);
			wr(gst_pkg::ADDR_CTRL, {inv, 1'h1, 6'h01}, gst_pkg::RESP_OKAY);
			repeat (40) @(posedge clk);
			wr(gst_pkg::ADDR_CTRL, 8'h00, gst_pkg::RESP_OKAY);
			rdc(c);
			chk(32'(c != 16'h0000), 32'(lvl == inv));
		end
		$display("test gate done");
	endtask

	// Time-zero values, reset for ten cycles, then the scenarios.
	initial begin
		rstn = 1'h0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, sleep, prim_xtal} = '0;
		prim_int = 1'h1;
		{err_total, checked, cyc, wakes} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		t_reset();
		t_int();
		t_ext();
		t_osc();
		t_gate();
		end_sim();
	end
endmodule
